// file: common/mbd_pkg.sv
package mbd_pkg;
  // clock and switching rates
  localparam int CLK_HZ    = 100_000_000;
  localparam int F_HIGH_HZ = 215_000;
  localparam int F_MED_HZ  = 135_000;
  localparam int F_LOW_HZ  = 110_000;
  localparam logic [11:0] PER_HIGH = 12'(CLK_HZ / F_HIGH_HZ);
  localparam logic [11:0] PER_MED  = 12'(CLK_HZ / F_MED_HZ);
  localparam logic [11:0] PER_LOW  = 12'(CLK_HZ / F_LOW_HZ);
  // dead time is a fraction of one switching period
  localparam int DT_NUM = 3;
  localparam int DT_DEN = 256;
  // bypass square wave, half period rounded down
  localparam int BYP_HZ = 440_000;
  localparam logic [7:0] BYP_HALF = 8'(CLK_HZ / (2 * BYP_HZ));
  // slow times in their own units
  localparam longint SLEW_FAST_MS = 60;
  localparam longint SLEW_SLOW_MS = 120;
  localparam longint SS_TIME_MS   = 250;
  localparam longint SS_STEPS     = 512;
  localparam longint START_S_SHORT = 60;
  localparam longint START_S_LONG  = 120;
  // status word layout
  localparam int STAT_W   = 56;
  localparam int CH_W     = 10;
  localparam int FLAG_BIT = 40;
  localparam logic [STAT_W-1:0] STAT_RST = '0;
  // i2c register pointer values
  localparam logic REG_CFG  = 1'b0;
  localparam logic REG_MEAS = 1'b1;
  localparam logic [6:0] I2C_ADDR_DEF = 7'h2c; // arbitrary target address

  typedef enum logic [2:0] {
    ST_CFG   = 3'b000,
    ST_SOFT  = 3'b001,
    ST_SBYP  = 3'b010,
    ST_STBY  = 3'b011,
    ST_TRACK = 3'b100,
    ST_BYP   = 3'b101
  } mbd_state_e;

  typedef enum logic [1:0] {
    SLEW_NONE = 2'b00,
    SLEW_FAST = 2'b01,
    SLEW_SLOW = 2'b10
  } mbd_slew_e;

  typedef struct packed {
    logic [9:0] ch6;
    logic [9:0] ch4;
    logic [9:0] ch2;
    logic [9:0] ch0;
  } mbd_samples_s;

  typedef struct packed {
    logic [9:0] vout;
    logic [9:0] output_current_sense;
    logic [9:0] vin;
    logic [9:0] iin;
  } mbd_meas_s;

  typedef struct packed {
    mbd_slew_e  slew;
    logic [1:0] start_sel; // 0: none, 1: short, 2: long
    logic [5:0] exit_k;    // thousandths of supply
    logic [5:0] start_k;
    logic       ratio12;
  } mbd_cfg6_s;

  // slew, start time, thresholds and ratio from the top sample bits
  function automatic mbd_cfg6_s decode_cfg6(input logic [2:0] c);
    case (c)
      3'h7:    decode_cfg6 = '{SLEW_SLOW, 2'h0, 6'h00, 6'h00, 1'b0};
      3'h6:    decode_cfg6 = '{SLEW_SLOW, 2'h1, 6'h06, 6'h0a, 1'b0};
      3'h5:    decode_cfg6 = '{SLEW_SLOW, 2'h0, 6'h17, 6'h27, 1'b0};
      3'h4:    decode_cfg6 = '{SLEW_SLOW, 2'h2, 6'h17, 6'h27, 1'b0};
      3'h3:    decode_cfg6 = '{SLEW_SLOW, 2'h0, 6'h06, 6'h0a, 1'b1};
      3'h2:    decode_cfg6 = '{SLEW_SLOW, 2'h1, 6'h27, 6'h17, 1'b0};
      3'h1:    decode_cfg6 = '{SLEW_FAST, 2'h1, 6'h17, 6'h27, 1'b0};
      default: decode_cfg6 = '{SLEW_NONE, 2'h1, 6'h17, 6'h27, 1'b0};
    endcase
  endfunction

  // supply reading times k thousandths
  function automatic logic [9:0] frac_of(input logic [9:0] r,
                                         input logic [5:0] k);
    frac_of = 10'((20'(r) * 20'(k)) / 20'd1000);
  endfunction

  // soft-start end point, 1:1 or 1:1.2
  function automatic logic ratio_met(input logic [9:0] vo,
                                     input logic [9:0] vi,
                                     input logic       r12);
    if (r12)
      ratio_met = (14'(vo) * 14'd10) >= (14'(vi) * 14'd12);
    else
      ratio_met = vo >= vi;
  endfunction

  // least dead time in cycles, rounded up
  function automatic logic [9:0] dead_cycles(input logic [11:0] per);
    dead_cycles = 10'((22'(per) * 22'(DT_NUM) + 22'(DT_DEN - 1))
                      / 22'(DT_DEN));
  endfunction
endpackage

// file: core/mbd_core.sv
// Functional notes
// [R1] fast slew: one volt per 60 ms
// [R2] slow slew: one volt per 120 ms
// [R3] after reset: soft start, then starting bypass
// [R4] current compared to start and exit levels
// [R5] soft start ends at configured output ratio
// [R6] dead time three 256ths of period
// [R7] forced-bypass low enters bypass from soft start, standby and tracking
// [R8] bypass active drives 440 kHz square wave
// [R9] reset low forces every drive off
// [R10] standby leaves once current above start
// [R11] status readable through the i2c target
// [R12] config sample word, read only, zero reset
// [R13] measurement word with tracking flag bit 40
// [R14] slew limiting only while boosting
// [R15] channel 2 picks frequency and bypass kind
// [R16] bridge bypass: half frequency, unity ratio
// [R17] dedicated bypass: bridge stops switching
// [R18] forced-bypass and reset pins synchronised
`timescale 1ns/1ps
module mbd_core #(
  parameter longint unsigned SLEW_FAST_CYC =
    mbd_pkg::SLEW_FAST_MS * mbd_pkg::CLK_HZ / 1000,
  parameter longint unsigned SLEW_SLOW_CYC =
    mbd_pkg::SLEW_SLOW_MS * mbd_pkg::CLK_HZ / 1000,
  parameter longint unsigned SS_STEP_CYC =
    mbd_pkg::SS_TIME_MS * mbd_pkg::CLK_HZ / 1000 / mbd_pkg::SS_STEPS,
  parameter longint unsigned START_SHORT_CYC =
    mbd_pkg::START_S_SHORT * mbd_pkg::CLK_HZ,
  parameter longint unsigned START_LONG_CYC =
    mbd_pkg::START_S_LONG * mbd_pkg::CLK_HZ,
  parameter logic [9:0]      VOLT_CODE = 10'h014,
  parameter logic [6:0]      I2C_ADDR  = mbd_pkg::I2C_ADDR_DEF
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 force_bypass_n,
  input  wire logic                 cfg_valid,
  input  wire mbd_pkg::mbd_samples_s cfg,
  input  wire logic                 meas_valid,
  input  wire mbd_pkg::mbd_meas_s   meas,
  input  wire logic [9:0]           analog_supply_ref,
  input  wire logic [8:0]           track_duty,
  input  wire logic                 track_unity,
  input  wire logic                 scl,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe_b,
  output logic                      bridge_a_high_drive,
  output logic                      bridge_a_low_drive,
  output logic                      bridge_b_high_drive,
  output logic                      bridge_b_low_drive,
  output logic                      bypass_switch_drive
);
  import mbd_pkg::*;

  // counters below are sized for these limits
  if (START_LONG_CYC >= 64'h4_0000_0000 || SLEW_SLOW_CYC >= 64'h100_0000
      || SS_STEP_CYC == 0 || SS_STEP_CYC >= 64'h4_0000_0000
      || VOLT_CODE == 10'h000)
    $error("mbd_core: timing parameter out of range");

  mbd_state_e        state;       // control phase
  mbd_state_e        next_state;
  logic              rst_meta;    // reset release synchroniser
  logic              rst_sync;
  logic              fb_meta;     // forced-bypass synchroniser
  logic              fb_sync;
  logic [33:0]       tmr;         // soft-start step and start bypass
  logic [8:0]        ss_duty;     // soft-start duty ramp
  logic [8:0]        duty;        // applied duty, bit 8 = boost
  logic [23:0]       hold;        // slew hold after each volt
  logic [9:0]        vmark;       // lowest output level since last volt step
  logic [11:0]       pwm_cnt;     // position in switching period
  logic [7:0]        byp_cnt;     // square wave half period
  logic              byp_q;
  logic [1:0]        raw;         // wanted high-side state per leg
  logic [1:0]        prv;
  logic [1:0]        hi;
  logic [1:0]        lo;
  logic [1:0][9:0]   dtc;         // dead time down counters
  logic [STAT_W-1:0] stat_cfg;    // config sample word
  logic [STAT_W-1:0] stat_meas;   // measurement word

  // settings decoded from the stored samples
  mbd_cfg6_s  c6;
  logic       dedicated;
  logic [11:0] per;
  logic [11:0] per_act;
  logic [11:0] comp;
  logic [9:0]  dt;
  logic [9:0]  vout, iout, vin;
  logic [9:0]  th_start, th_exit;
  logic        byp_on, brg_byp, brg_en;
  logic [8:0]  req;

  assign c6       = decode_cfg6(stat_cfg[39:37]);
  assign vout     = stat_meas[39:30];
  assign iout     = stat_meas[29:20];
  assign vin      = stat_meas[19:10];
  assign th_start = frac_of(analog_supply_ref, c6.start_k); // [R4]
  assign th_exit  = frac_of(analog_supply_ref, c6.exit_k);  // [R4]
  assign byp_on   = (state == ST_SBYP) || (state == ST_BYP);
  assign brg_byp  = byp_on && !dedicated;
  assign brg_en   = (state == ST_SOFT) || (state == ST_TRACK) || brg_byp;
  assign req      = (state == ST_SOFT) ? ss_duty : track_duty;
  assign dt       = dead_cycles(per); // [R6]

  // frequency and bypass kind from channel 2
  always_comb begin
    dedicated = 1'b1; // [R15]
    per       = PER_HIGH;
    case (stat_cfg[19:17])
      3'h5:    begin per = PER_LOW;  dedicated = 1'b0; end
      3'h4:    begin per = PER_MED;  dedicated = 1'b0; end
      3'h3:    begin per = PER_HIGH; dedicated = 1'b0; end
      3'h2:    per = PER_LOW;
      3'h1:    per = PER_MED;
      default: per = PER_HIGH;
    endcase
    // bridge bypass runs at half the frequency
    per_act = brg_byp ? 12'(per << 1) : per; // [R16]
    comp = 12'((20'(duty[7:0]) * 20'(per_act)) >> 8);
  end

  // reset: asserts at once, releases after two edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0; // [R18]
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // forced-bypass pin, idle high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fb_meta <= 1'b1;
      fb_sync <= 1'b1;
    end else begin
      fb_meta <= force_bypass_n; // [R18]
      fb_sync <= fb_meta;
    end
  end

  // phase sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_CFG:
        if (rst_sync && cfg_valid) next_state = ST_SOFT;
      ST_SOFT:
        if (!fb_sync) next_state = ST_BYP; // [R7]
        else if (iout > th_start) next_state = ST_TRACK;
        else if (ratio_met(vout, vin, c6.ratio12))
          next_state = ST_SBYP; // [R5] [R3]
      ST_SBYP:
        if (tmr == '0) next_state = ST_STBY; // [R3]
      ST_STBY:
        if (!fb_sync) next_state = ST_BYP; // [R7]
        else if (iout > th_start) next_state = ST_TRACK; // [R10]
      ST_TRACK:
        if (!fb_sync) next_state = ST_BYP; // [R7]
        else if (iout < th_exit) next_state = ST_STBY; // [R4]
        else if (track_unity) next_state = ST_BYP;
      ST_BYP:
        if (fb_sync && !track_unity) next_state = ST_TRACK;
      default: next_state = ST_CFG;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) state <= ST_CFG; // [R9]
    else        state <= next_state;
  end

  // shared timer: ramp steps, then the starting bypass time
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tmr     <= '0;
      ss_duty <= '0;
    end else if (state == ST_SOFT && next_state == ST_SBYP) begin
      case (c6.start_sel)
        2'h1:    tmr <= 34'(START_SHORT_CYC); // [R3]
        2'h2:    tmr <= 34'(START_LONG_CYC);
        default: tmr <= '0;
      endcase
    end else if (state == ST_SOFT) begin
      if (tmr == '0) begin
        tmr <= 34'(SS_STEP_CYC - 1);
        if (ss_duty != 9'h1ff) ss_duty <= ss_duty + 9'd1;
      end else begin
        tmr <= tmr - 34'd1;
      end
    end else if (tmr != '0) begin
      tmr <= tmr - 34'd1;
    end
  end

  // output ramp limiter: each volt of rise starts a hold
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold  <= '0;
      vmark <= '0;
    end else if (meas_valid && meas.vout >= 10'(vmark + VOLT_CODE)) begin
      vmark <= meas.vout;
      case (c6.slew)
        SLEW_FAST: hold <= 24'(SLEW_FAST_CYC); // [R1]
        SLEW_SLOW: hold <= 24'(SLEW_SLOW_CYC); // [R2]
        default:   hold <= '0;
      endcase
    end else begin
      if (meas_valid && meas.vout < vmark) vmark <= meas.vout;
      if (hold != '0) hold <= hold - 24'd1;
    end
  end

  // applied duty; rises in boost wait out the hold
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) duty <= '0;
    else if (!(hold != '0 && req[8] && req > duty)) duty <= req; // [R14]
  end

  // switching period counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) pwm_cnt <= '0;
    else if (pwm_cnt >= per_act - 12'd1) pwm_cnt <= '0;
    else pwm_cnt <= pwm_cnt + 12'd1;
  end

  // wanted leg states: buck switches leg a, boost leg b
  always_comb begin
    if (brg_byp) begin
      raw = {2{pwm_cnt < per}}; // [R16]
    end else if (duty[8]) begin
      raw = {pwm_cnt >= comp, 1'b1};
    end else begin
      raw = {1'b1, pwm_cnt < comp};
    end
  end

  // dead time: both switches of a leg off after each change
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prv <= '0;
      dtc <= '0;
      hi  <= '0; // [R9]
      lo  <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        prv[i] <= raw[i];
        if (raw[i] != prv[i]) begin
          dtc[i] <= dt - 10'd1; // [R6]
          hi[i]  <= 1'b0;
          lo[i]  <= 1'b0;
        end else if (dtc[i] != '0) begin
          dtc[i] <= dtc[i] - 10'd1;
          hi[i]  <= 1'b0;
          lo[i]  <= 1'b0;
        end else begin
          // dedicated bypass and idle phases stop the bridge
          hi[i] <= raw[i] & brg_en;  // [R17]
          lo[i] <= ~raw[i] & brg_en;
        end
      end
    end
  end

  assign bridge_a_high_drive = hi[0];
  assign bridge_a_low_drive  = lo[0];
  assign bridge_b_high_drive = hi[1];
  assign bridge_b_low_drive  = lo[1];

  // bypass switch square wave, low whenever bypass is off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      byp_cnt <= '0;
      byp_q   <= 1'b0; // [R9]
    end else if (!byp_on) begin
      byp_cnt <= '0;
      byp_q   <= 1'b0;
    end else if (byp_cnt == BYP_HALF - 8'd1) begin
      byp_cnt <= '0;
      byp_q   <= ~byp_q; // [R8]
    end else begin
      byp_cnt <= byp_cnt + 8'd1;
    end
  end

  assign bypass_switch_drive = byp_q;

  // status words; reserved upper bits stay zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_cfg  <= STAT_RST;
      stat_meas <= STAT_RST;
    end else begin
      // samples are taken once per reset
      if (state == ST_CFG && rst_sync && cfg_valid)
        stat_cfg <= {16'h0000, cfg}; // [R12]
      if (meas_valid)
        stat_meas <= {15'h0000, state == ST_TRACK, meas}; // [R13]
    end
  end

  // register access from the bus
  mbd_i2c_target #(
    .ADDR      (I2C_ADDR)
  ) u_i2c (
    .clk       (clk),
    .rst_b     (rst_b),
    .scl       (scl),
    .sda_in    (sda_in),
    .sda_out   (sda_out),
    .sda_oe_b  (sda_oe_b),
    .stat_cfg  (stat_cfg),
    .stat_meas (stat_meas)
  ); // [R11]

  // checks
  leg_overlap_a: // [R6]
    assert property (@(posedge clk) disable iff (!rst_b)
      !(hi[0] && lo[0]) && !(hi[1] && lo[1]))
    else $error("leg high and low on together");
  dead_gap_a: // [R6]
    assert property (@(posedge clk) disable iff (!rst_b)
      $fell(hi[0]) |-> (!lo[0])[*6])
    else $error("dead time too short on leg a");
  forced_byp_a: // [R7]
    assert property (@(posedge clk) disable iff (!rst_b)
      (state == ST_TRACK && !fb_sync) |=> state == ST_BYP)
    else $error("forced bypass not entered");
  square_wave_a: // [R8]
    assert property (@(posedge clk) disable iff (!rst_b)
      (byp_on && $rose(byp_q)) |=> (byp_on && byp_q)[*8] or !byp_on)
    else $error("bypass wave half period too short");
  reset_off_a: // [R9]
    assert property (@(posedge clk)
      !rst_sync |-> (hi == 2'b00 && lo == 2'b00 && !byp_q))
    else $error("drive active during reset");
  start_track_a: // [R10]
    assert property (@(posedge clk) disable iff (!rst_b)
      (state == ST_STBY && fb_sync && iout > th_start)
      |=> state == ST_TRACK)
    else $error("standby did not start tracking");
  soft_end_a: // [R5]
    assert property (@(posedge clk) disable iff (!rst_b)
      (state == ST_SOFT && fb_sync && !(iout > th_start)
       && ratio_met(vout, vin, c6.ratio12)) |=> state == ST_SBYP)
    else $error("soft start did not end at ratio");
  dedicated_off_a: // [R17]
    assert property (@(posedge clk) disable iff (!rst_b)
      (state == ST_BYP && $past(state) == ST_BYP && dedicated)
      |-> (hi == 2'b00 && lo == 2'b00))
    else $error("bridge switching in dedicated bypass");
  slew_hold_a: // [R14]
    assert property (@(posedge clk) disable iff (!rst_b)
      (hold != '0 && duty[8] && req > duty) |=> duty == $past(duty))
    else $error("boost duty rose during slew hold");
  cfg_word_a: // [R12]
    assert property (@(posedge clk) disable iff (!rst_b)
      stat_cfg[55:40] == 16'h0000 && stat_meas[55:41] == 15'h0000)
    else $error("reserved status bits not zero");
endmodule

// file: core/mbd_i2c_target.sv
`timescale 1ns/1ps
module mbd_i2c_target #(
  parameter logic [6:0] ADDR = mbd_pkg::I2C_ADDR_DEF
) (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      scl,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe_b,
  input  wire logic [mbd_pkg::STAT_W-1:0] stat_cfg,
  input  wire logic [mbd_pkg::STAT_W-1:0] stat_meas
);
  import mbd_pkg::*;

  typedef enum logic [2:0] {
    I_IDLE = 3'b000, I_ADDR = 3'b001, I_ACKA = 3'b010, I_WR = 3'b011,
    I_ACKW = 3'b100, I_RD = 3'b101, I_ACKR = 3'b110
  } mbd_i2c_e;

  mbd_i2c_e   st;       // bus phase
  logic       scl_q;    // previous line samples
  logic       sda_q;
  logic [3:0] bitc;     // bits of the current byte
  logic [7:0] sh;       // shift register
  logic       rw;       // 1: master reads
  logic       ptr;      // selected status word
  logic       ptr_set;  // pointer byte already taken
  logic [2:0] idx;      // byte index, msb byte first
  logic       nack;

  wire rise  = scl & ~scl_q;
  wire fall  = ~scl & scl_q;
  wire start = scl & scl_q & sda_q & ~sda_in;
  wire stop  = scl & scl_q & ~sda_q & sda_in;

  // seven bytes per word; bytes past the end read zero
  function automatic logic [7:0] byte_of(input logic p,
                                         input logic [2:0] i);
    logic [STAT_W-1:0] w;
    w = (p == REG_MEAS) ? stat_meas : stat_cfg;
    byte_of = (i > 3'd6) ? 8'h00 : 8'(w >> (8 * (6 - int'(i))));
  endfunction

  // open drain: the level is always low, only the enable moves
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) sda_out <= 1'b0;
    else        sda_out <= 1'b0;
  end

  // line history for edge and start/stop detection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  // protocol engine; stop and start win over any phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= I_IDLE; bitc <= '0; sh <= '0; rw <= 1'b0;
      ptr <= REG_CFG; ptr_set <= 1'b0; idx <= '0; nack <= 1'b0;
      sda_oe_b <= 1'b1;
    end else if (stop) begin
      st <= I_IDLE;
      sda_oe_b <= 1'b1;
    end else if (start) begin
      st <= I_ADDR; bitc <= '0; idx <= '0; ptr_set <= 1'b0;
      sda_oe_b <= 1'b1;
    end else begin
      case (st)
        I_ADDR, I_WR: begin
          if (rise && bitc != 4'd8) begin
            sh <= {sh[6:0], sda_in};
            bitc <= bitc + 4'd1;
          end else if (fall && bitc == 4'd8) begin
            bitc <= '0;
            if (st == I_ADDR) begin
              // other addresses are ignored until the next start
              if (sh[7:1] == ADDR) begin
                st <= I_ACKA; rw <= sh[0]; sda_oe_b <= 1'b0;
              end else begin
                st <= I_IDLE;
              end
            end else begin
              // only the first written byte counts, as the pointer
              if (!ptr_set) ptr <= sh[0];
              ptr_set <= 1'b1;
              st <= I_ACKW; sda_oe_b <= 1'b0;
            end
          end
        end
        I_ACKA: if (fall) begin
          if (rw) begin
            st <= I_RD; sh <= byte_of(ptr, idx);
            sda_oe_b <= byte_of(ptr, idx) [7];
          end else begin
            st <= I_WR; sda_oe_b <= 1'b1;
          end
        end
        I_ACKW: if (fall) begin
          st <= I_WR; sda_oe_b <= 1'b1;
        end
        I_RD: if (fall) begin
          bitc <= bitc + 4'd1;
          if (bitc == 4'd7) begin
            st <= I_ACKR; sda_oe_b <= 1'b1; bitc <= '0;
            idx <= idx + 3'd1;
          end else begin
            sh <= {sh[6:0], 1'b0};
            sda_oe_b <= sh[6];
          end
        end
        I_ACKR: begin
          if (rise) nack <= sda_in;
          if (fall) begin
            if (nack) begin
              st <= I_IDLE;
            end else begin
              st <= I_RD; sh <= byte_of(ptr, idx);
              sda_oe_b <= byte_of(ptr, idx) [7];
            end
          end
        end
        default: st <= I_IDLE;
      endcase
    end
  end
endmodule

// file: verification/mbd_gate_model.sv
`timescale 1ns/1ps
// one bridge leg as a gate driver sees it: counts shoot-through and
// any turn-on that follows an off edge by fewer than DT idle cycles
module mbd_gate_model #(
  parameter int DT = 6
) (
  input  wire logic clk,
  input  wire logic hi,
  input  wire logic lo,
  output int        faults
);
  int gap = 1000; // idle cycles seen before this edge
  initial faults = 0;
  // a real driver would cross-conduct here, so no tolerance is given
  always @(posedge clk) begin
    if ((hi && lo) || (($rose(hi) || $rose(lo)) && gap < DT)) begin
      faults <= faults + 1;
    end
    gap <= (hi || lo) ? 0 : gap + 1;
  end
endmodule

// file: verification/test_mppt_bridge_drive_and_status.sv
`timescale 1ns/1ps
module test_mppt_bridge_drive_and_status;
  import mbd_pkg::*;
  localparam int DT = (3 * int'(PER_HIGH) + 255) / 256; // high rate gap
  logic clk = 0, rst_b = 0, force_bypass_n = 1, cfg_valid = 0;
  logic meas_valid = 0, scl = 1, sda_m = 1, tunity = 0;
  logic [9:0] asr = 10'h3ff; // supply reading, thresholds scale from it
  logic [8:0] tduty = 9'h080; // tracker duty, buck half
  mbd_samples_s cfg = '{10'h3a5, 10'h2c3, 10'h3c1, 10'h155}; // ch2 high
  mbd_meas_s meas = '{10'h1a2, 10'h0b4, 10'h2f1, 10'h07e};
  wire sda_out, sda_oe_b, ah, al, bh, bl, byp;
  wire sda = sda_m & (sda_oe_b | sda_out); // open drain with pull-up
  int mismatches = 0, check_count = 0, cycles = 0, fa, fb;
  logic [55:0] w;
  mbd_core #(.SLEW_FAST_CYC(20), .SLEW_SLOW_CYC(40), .SS_STEP_CYC(4),
    .START_SHORT_CYC(50), .START_LONG_CYC(100)) dut (.clk(clk),
    .rst_b(rst_b), .force_bypass_n(force_bypass_n), .cfg_valid(cfg_valid),
    .cfg(cfg), .meas_valid(meas_valid), .meas(meas),
    .analog_supply_ref(asr), .track_duty(tduty), .track_unity(tunity),
    .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_b(sda_oe_b),
    .bridge_a_high_drive(ah), .bridge_a_low_drive(al),
    .bridge_b_high_drive(bh), .bridge_b_low_drive(bl),
    .bypass_switch_drive(byp));
  mbd_gate_model #(.DT(DT)) leg_a (.clk(clk), .hi(ah), .lo(al), .faults(fa));
  mbd_gate_model #(.DT(DT)) leg_b (.clk(clk), .hi(bh), .lo(bl), .faults(fb));
  initial forever #5 clk = ~clk;
  // hang guard, soft start plus two bus reads fit well inside
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [55:0] e,
                     input logic [55:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic i2c_bit(input logic b, output logic r);
    sda_m = b;
    cyc(3);
    scl = 1;
    cyc(3);
    r = sda;
    scl = 0;
    cyc(1);
  endtask
  task automatic i2c_start;
    sda_m = 1;
    cyc(2);
    scl = 1;
    cyc(3);
    sda_m = 0;
    cyc(3);
    scl = 0;
    cyc(2);
  endtask
  task automatic i2c_byte(input logic [7:0] d, input logic m_ack,
                          output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) i2c_bit(d[i], q[i]);
    i2c_bit(m_ack, a);
  endtask
  // pointer write, repeated start, seven bytes most significant first
  task automatic read_word(input logic p, output logic [55:0] r);
    logic [7:0] q;
    i2c_start();
    i2c_byte({I2C_ADDR_DEF, 1'b0}, 1'b1, q);
    i2c_byte({7'h0, p}, 1'b1, q);
    i2c_start();
    i2c_byte({I2C_ADDR_DEF, 1'b1}, 1'b1, q);
    for (int k = 0; k < 7; k++) begin
      i2c_byte(8'hff, k == 6, q);
      r = {r[47:0], q};
    end
    sda_m = 0;
    cyc(2);
    scl = 1;
    cyc(3);
    sda_m = 1;
    cyc(3);
  endtask
  // all drives off and sda released, no clock edge needed
  task automatic test_drives_off;
    chk("drives", 56'h1, {50'h0, ah, al, bh, bl, byp, sda_oe_b});
  endtask
  task automatic wait_change(output int n);
    logic b0;
    b0 = byp;
    n = 0;
    while (byp === b0 && n < 300) begin
      cyc(1);
      n++;
    end
  endtask
  // soft start meets the ratio on zero readings and ends in one cycle; gate models judge every gap
  task automatic test_soft_start;
    cyc(2);
    cfg_valid = 1;
    cyc(1);
    cfg_valid = 0;
    cyc(2600);
    chk("leg faults", 56'h0, 56'(fa + fb));
  endtask
  task automatic test_forced_bypass;
    int n;
    force_bypass_n = 0;
    cyc(5);
    wait_change(n);
    wait_change(n);
    chk("wave half period", 56'd113, 56'(n));
    chk("bridge idle", 56'h0, {52'h0, ah, al, bh, bl});
  endtask
  task automatic test_status;
    read_word(REG_CFG, w);
    chk("config word", {16'h0, cfg}, w);
    meas_valid = 1;
    cyc(1);
    meas_valid = 0;
    read_word(REG_MEAS, w);
    chk("measure word", {16'h0, meas}, w);
  endtask
  // pin released: tracking, wave stops; unity ratio brings it back
  task automatic test_unity_bypass;
    int n;
    force_bypass_n = 1;
    cyc(6);
    chk("wave off in tracking", 56'h0, 56'(byp));
    tunity = 1;
    wait_change(n);
    wait_change(n);
    chk("unity wave half period", 56'd113, 56'(n));
    chk("leg faults tracking", 56'h0, 56'(fa + fb));
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    cyc(1);
    test_drives_off();
    cyc(3);
    rst_b = 1;
    test_soft_start();
    test_forced_bypass();
    test_status();
    test_unity_bypass();
    rst_b = 0;
    #1;
    test_drives_off();
    complete_run();
  end
endmodule
